// [ecc_secded.sv]
// Seven-bit single-correct double-detect code over one 32-bit double word
`timescale 1ns/1ps
module ecc_secded (
  // Word and stored check bits
  input wire logic [31:0] data_in,
  input wire logic [6:0] check_in,
  // Encoded check bits for data_in
  output logic [6:0] check_out,
  // Decoded word and fault indications
  output logic [31:0] data_out,
  output logic single_fault,
  output logic double_fault
);
  logic [38:0] cw;
  logic [38:0] fix;
  logic [5:0] syn;
  logic overall;

  // Spread data over non power of two positions, then build parity
  always_comb begin
    automatic int j = 0;
    cw = '0;
    check_out = '0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = data_in[j];
        j++;
      end
    end
    for (int k = 0; k < 6; k++) begin
      for (int p = 1; p < 39; p++) begin
        if (p[k]) begin
          check_out[k] = check_out[k] ^ cw[p];
        end
      end
    end
    check_out[6] = ^{data_in, check_out[5:0]};
  end

  // Syndrome, fault class and correction
  always_comb begin
    automatic int j = 0;
    syn = check_in[5:0] ^ check_out[5:0];
    overall = ^{data_in, check_in};
    single_fault = overall;
    double_fault = !overall && (syn != 6'h00);
    fix = cw;
    if (overall && syn != 6'h00 && syn < 6'h27) begin
      fix[syn] = !cw[syn];
    end
    data_out = '0;
    for (int p = 1; p < 39; p++) begin
      if ((p & (p - 1)) != 0) begin
        data_out[j] = fix[p];
        j++;
      end
    end
  end
endmodule

// [flash_array_model.sv]
// Behavioural flash array facing the controller's read and write side
`timescale 1ns/1ps
module flash_array_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Read side
  input wire logic [17:0] arr_addr,
  input wire logic arr_data_sel,
  output logic [38:0] arr_rdata,
  // Write side and fault injection
  input wire flash_pkg::arr_wr_t arr_wr,
  input wire logic [1:0] flip
);
  import flash_pkg::*;
  logic [38:0] mem_q [0:1][0:63]; // Half phrases with their check bits
  logic [38:0] flip_mask; // Bits upset on the way out
  // erased cells are ones, erase clears a sector
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 128; i++) mem_q[i/64][i%64] <= '1;
    end else if (arr_wr.op == OP_ERASE) begin
      // A program sector is wider than this model, so all of it goes
      for (int i = 0; i < 64; i++)
        if (!arr_wr.data_array || i == arr_wr.addr[7:2])
          mem_q[arr_wr.data_array][i] <= '1;
    end else if (arr_wr.op == OP_PROG) begin
      // two double words with seven check bits each
      mem_q[arr_wr.data_array][arr_wr.addr[7:2]] <=
        {arr_wr.check[6:0], arr_wr.phrase[31:0]};
      mem_q[arr_wr.data_array][arr_wr.addr[7:2] + 6'h01] <=
        {arr_wr.check[13:7], arr_wr.phrase[63:32]};
    end
  end
  // half phrase out, one or two bits upset on request
  always_comb begin
    flip_mask = '0;
    if (flip != 2'h0) flip_mask[3] = 1'b1;
    if (flip == 2'h2) flip_mask[9] = 1'b1;
    arr_rdata = mem_q[arr_data_sel][arr_addr[7:2]] ^ flip_mask;
  end
endmodule

// [flash_ctrl.sv]
// Flash read path with ECC, fault forcing, interrupts and registers
// Operation
// - Command irq when done flag and enable
// - One error irq from enabled fault flags
// - Config bit 7 enables command irq
// - Config bit 4 hides single faults; the code hides genuine ones only, forced ones still flag
// - Forced double fault on every read
// - Forced single fault on every read
// - Force bits clear only by software
// - Unforced flags follow genuine faults only
// - Byte and aligned word reads in one cycle
// - Erased bit reads one, programmed zero
// - Program reads served during data commands
// - Data reads held during program commands
// - Both arrays corrected and checked by ECC
// - Programming uses aligned eight byte phrases
// - Reads fetch aligned four byte half phrase
// - Seven check bits per double word
// - Program sector is 512 bytes
// - Data sector is 4 bytes
// - Twenty registers decoded at indices 0-0x13
// - Information region with version and once field
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "flash_defines.svh"
module flash_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire flash_pkg::axil_req_t axi_req,
  output flash_pkg::axil_rsp_t axi_rsp,
  // Core array reads
  input wire flash_pkg::rd_req_t rd_req,
  output flash_pkg::rd_rsp_t rd_rsp,
  // Array read side
  output logic [17:0] arr_addr,
  output logic arr_data_sel,
  output logic arr_info_sel,
  input wire logic [38:0] arr_rdata,
  // Command sequencer
  input wire flash_pkg::seq_req_t seq_req,
  output logic cmd_start,
  output flash_pkg::arr_wr_t arr_wr,
  // Interrupt requests
  output logic irq_cmd,
  output logic irq_err
);
  import flash_pkg::*;

  ctrl_state_t st_q; // Registered state
  ctrl_state_t st_d; // Next state
  logic rd_fire; // Read taken this cycle
  logic misalign; // Word read on odd byte
  logic erased; // Raw half phrase fully erased
  logic [31:0] dec_data; // Corrected half phrase
  logic dec_sgl; // Genuine single fault
  logic dec_dbl; // Genuine double fault
  logic [13:0] enc_check; // Check bits for a phrase
  logic busy; // Any command running
  logic wr_do; // Register write performed now
  logic [4:0] wr_idx; // Written register index
  logic wr_ok; // Write accepted
  logic [15:0] half; // Selected word of the half phrase

  // Register index from a byte address
  function automatic logic [4:0] reg_index(input logic [7:0] a);
    reg_index = a[6:2];
  endfunction

  // Address lies inside the twenty registers
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && ({2'h0, a[7:2]} < `REG_COUNT);
  endfunction

  // Decode of the fetched half phrase
  ecc_secded u_dec (
    .data_in(arr_rdata[31:0]),
    .check_in(arr_rdata[38:32]),
    .check_out(),
    .data_out(dec_data),
    .single_fault(dec_sgl),
    .double_fault(dec_dbl)
  );

  generate
    for (genvar g = 0; g < 2; g++) begin : g_enc
      ecc_secded u_enc (
        .data_in(seq_req.phrase[32*g+:32]),
        .check_in(7'h00),
        .check_out(enc_check[7*g+:7]),
        .data_out(),
        .single_fault(),
        .double_fault()
      );
    end
  endgenerate

  assign busy = seq_req.busy_prog || seq_req.busy_data;

  assign arr_addr = rd_req.addr & ~`HALF_MASK;
  assign arr_data_sel = rd_req.data_array;
  assign arr_info_sel = !rd_req.data_array &&
    rd_req.addr >= `INFO_BASE && rd_req.addr <= `INFO_LAST;

  // data reads wait out program commands, program reads do not
  assign rd_rsp.ready = !(rd_req.data_array && seq_req.busy_prog);
  assign rd_fire = rd_req.valid && rd_rsp.ready;
  // misaligned words are refused with an error
  assign misalign = rd_req.word && rd_req.addr[0];
  // erased cells read as ones and carry no fault
  assign erased = (arr_rdata == '1);
  // an erased half phrase bypasses the decoder
  assign half = erased ? 16'hFFFF :
    (rd_req.addr[1] ? dec_data[31:16] : dec_data[15:0]);

  // Bus handshakes are combinational from the state
  assign axi_rsp.awready = !st_q.aw_got && !st_q.bvalid;
  assign axi_rsp.wready = !st_q.w_got && !st_q.bvalid;
  assign axi_rsp.arready = !st_q.rvalid;
  assign axi_rsp.bvalid = st_q.bvalid;
  assign axi_rsp.bresp = st_q.bresp;
  assign axi_rsp.rvalid = st_q.rvalid;
  assign axi_rsp.rdata = st_q.rdata;
  assign axi_rsp.rresp = st_q.rresp;
  assign rd_rsp.ack = st_q.rd_ack;
  assign rd_rsp.err = st_q.rd_err;
  assign rd_rsp.data = st_q.rd_data;
  assign cmd_start = st_q.cmd_start;
  assign arr_wr = st_q.wr;

  // Write decode from the captured address
  assign wr_do = st_q.aw_got && st_q.w_got && !st_q.bvalid;
  assign wr_idx = reg_index(st_q.aw_addr);
  // decode, writes during a command are refused
  assign wr_ok = reg_hit(st_q.aw_addr) && !busy;

  assign irq_cmd = st_q.done_flag && st_q.cmd_config[`CFG_CMD_IE];
  assign irq_err = (st_q.dbl_flag && st_q.err_config[`ERR_DBL]) ||
    (st_q.sgl_flag && st_q.err_config[`ERR_SGL]);

  // Next state of the whole controller
  always_comb begin
    st_d = st_q;
    st_d.cmd_start = 1'b0;
    st_d.rd_ack = 1'b0;
    st_d.wr.op = OP_NONE;
    // Capture write address and data in either order
    if (axi_req.awvalid && axi_rsp.awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      st_d.w_got = 1'b1;
      st_d.w_data = axi_req.wdata[7:0];
      st_d.w_lane0 = axi_req.wstrb[0];
    end
    // Perform the write once both halves are held
    if (wr_do) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      if (wr_ok && st_q.w_lane0) begin
        unique case (wr_idx)
          `IDX_CMD_CONFIG: begin
            st_d.cmd_config = st_q.w_data & 8'h93;
          end
          `IDX_ERR_CONFIG: begin
            st_d.err_config = st_q.w_data & 8'h03;
          end
          // Writing one clears done and launches the command
          `IDX_CMD_STATUS: begin
            if (st_q.w_data[`STS_DONE]) begin
              st_d.done_flag = 1'b0;
              st_d.cmd_start = 1'b1;
            end
            if (st_q.w_data[`STS_ALIGN_ERR]) begin
              st_d.align_err = 1'b0;
            end
          end
          // flags stay until cleared by a one
          `IDX_ERR_STATUS: begin
            if (st_q.w_data[`ERR_DBL]) begin
              st_d.dbl_flag = 1'b0;
            end
            if (st_q.w_data[`ERR_SGL]) begin
              st_d.sgl_flag = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (st_q.bvalid && axi_req.bready) begin
      st_d.bvalid = 1'b0;
    end
    // Register reads; the other indices read as zero
    if (axi_req.arvalid && axi_rsp.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = 32'h0000_0000;
      st_d.rresp = reg_hit(axi_req.araddr) ? `RESP_OKAY : `RESP_SLVERR;
      unique case (reg_index(axi_req.araddr))
        `IDX_CMD_CONFIG: begin
          st_d.rdata[7:0] = st_q.cmd_config;
        end
        `IDX_ERR_CONFIG: begin
          st_d.rdata[7:0] = st_q.err_config;
        end
        `IDX_CMD_STATUS: begin
          st_d.rdata[`STS_DONE] = st_q.done_flag;
          st_d.rdata[`STS_BUSY_PROG] = seq_req.busy_prog;
          st_d.rdata[`STS_BUSY_DATA] = seq_req.busy_data;
          st_d.rdata[`STS_ALIGN_ERR] = st_q.align_err;
        end
        `IDX_ERR_STATUS: begin
          st_d.rdata[`ERR_DBL] = st_q.dbl_flag;
          st_d.rdata[`ERR_SGL] = st_q.sgl_flag;
        end
        default: begin
        end
      endcase
    end
    if (st_q.rvalid && axi_req.rready) begin
      st_d.rvalid = 1'b0;
    end
    // Command completion sets the flag, winning over a clear
    if (seq_req.complete) begin
      st_d.done_flag = 1'b1;
    end
    // answer every taken read on the next edge
    if (rd_fire) begin
      st_d.rd_ack = 1'b1;
      st_d.rd_err = misalign;
      // corrected data, erased cells read as ones
      if (rd_req.word) begin
        st_d.rd_data = half;
      end else begin
        st_d.rd_data = {8'h00, rd_req.addr[0] ? half[15:8] : half[7:0]};
      end
      // forced double fault, else only a genuine one
      if (st_q.cmd_config[`CFG_FORCE_DBL] || (dec_dbl && !erased)) begin
        st_d.dbl_flag = 1'b1;
        st_d.rd_err = 1'b1;
      end
      // forced single fault, genuine ones may be hidden
      if (st_q.cmd_config[`CFG_FORCE_SGL] || (dec_sgl && !erased &&
          !st_q.cmd_config[`CFG_SUPPRESS])) begin
        st_d.sgl_flag = 1'b1;
      end
    end
    // Program and erase orders towards the array
    unique case (seq_req.op)
      OP_PROG: begin
        if ((seq_req.addr & `PHRASE_MASK) == 18'h00000) begin
          st_d.wr.op = OP_PROG;
          st_d.wr.data_array = seq_req.data_array;
          st_d.wr.addr = seq_req.addr;
          st_d.wr.phrase = seq_req.phrase;
          st_d.wr.check = enc_check;
        end else begin
          st_d.align_err = 1'b1;
        end
      end
      OP_ERASE: begin
        st_d.wr.op = OP_ERASE;
        st_d.wr.data_array = seq_req.data_array;
        st_d.wr.addr = seq_req.addr & ~(seq_req.data_array ?
          `DATA_SECTOR_MASK : `PROG_SECTOR_MASK);
      end
      OP_NONE: begin
      end
      default: begin
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
      st_q.cmd_config <= `RST_CMD_CONFIG;
      st_q.err_config <= `RST_ERR_CONFIG;
    end else begin
      st_q <= st_d;
    end
  end

  // Helper: register write with a byte in lane 0 to the config register
  logic cfg_wr;
  assign cfg_wr = wr_do && wr_ok && st_q.w_lane0 &&
    wr_idx == `IDX_CMD_CONFIG;

  AST_CMD_IRQ: assert property (@(posedge sys_clk)
    disable iff (!reset_n) seq_req.complete && !cfg_wr &&
    st_q.cmd_config[`CFG_CMD_IE] |=> irq_cmd) else $error("no command irq");
  AST_CMD_IE_OFF: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !st_q.cmd_config[`CFG_CMD_IE] |-> !irq_cmd)
    else $error("command irq while disabled");
  AST_ERR_IRQ: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_fire && st_q.cmd_config[`CFG_FORCE_DBL] &&
    st_q.err_config[`ERR_DBL] && !wr_do ##1 !wr_do |-> irq_err)
    else $error("error irq missing");
  AST_SUPPRESS: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !st_q.sgl_flag && st_q.cmd_config[`CFG_SUPPRESS] &&
    !st_q.cmd_config[`CFG_FORCE_SGL] |=> !st_q.sgl_flag)
    else $error("single fault reported while suppressed");
  AST_FORCE_DBL: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_fire && st_q.cmd_config[`CFG_FORCE_DBL]
    |=> st_q.dbl_flag && rd_rsp.err) else $error("forced double missed");
  AST_FORCE_SGL: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_fire && st_q.cmd_config[`CFG_FORCE_SGL]
    |=> st_q.sgl_flag) else $error("forced single fault not flagged");
  AST_FORCE_HOLD: assert property (@(posedge sys_clk)
    disable iff (!reset_n) !cfg_wr |=> $stable(st_q.cmd_config))
    else $error("force bit dropped without a write");
  AST_ONE_CYCLE: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_fire |=> rd_rsp.ack ##1 !rd_rsp.ack ||
    $past(rd_fire)) else $error("array read not answered in one cycle");
  AST_DATA_HOLD: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_req.valid && rd_req.data_array &&
    seq_req.busy_prog |-> !rd_rsp.ready) else $error("data read served");
  AST_PROG_SERVE: assert property (@(posedge sys_clk)
    disable iff (!reset_n) rd_req.valid && !rd_req.data_array &&
    seq_req.busy_data |=> rd_rsp.ack) else $error("program read stalled");
  AST_IRQ_LEVEL: assert property (@(posedge sys_clk)
    disable iff (!reset_n) irq_err && !wr_do |=> irq_err)
    else $error("error irq dropped without software");

  COV_FORCED_DBL: cover property (@(posedge sys_clk) disable iff (!reset_n)
    rd_fire && st_q.cmd_config[`CFG_FORCE_DBL] ##1 irq_err);
  COV_CMD_DONE: cover property (@(posedge sys_clk) disable iff (!reset_n)
    cmd_start ##[1:50] irq_cmd);
  COV_DATA_STALL: cover property (@(posedge sys_clk) disable iff (!reset_n)
    rd_req.valid && !rd_rsp.ready ##1 rd_fire);
endmodule

// [flash_defines.svh]
// Register offsets, bit positions, reset values and array constants
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH
// Register indices (byte address is four times the index)
`define REG_COUNT 8'h14
`define IDX_CMD_CONFIG 5'h04
`define IDX_ERR_CONFIG 5'h05
`define IDX_CMD_STATUS 5'h06
`define IDX_ERR_STATUS 5'h07
// Bits of flash_cmd_config
`define CFG_CMD_IE 7
`define CFG_SUPPRESS 4
`define CFG_FORCE_DBL 1
`define CFG_FORCE_SGL 0
// Bits of error_irq_config and error_status
`define ERR_DBL 1
`define ERR_SGL 0
// Bits of command_status
`define STS_DONE 7
`define STS_BUSY_PROG 6
`define STS_BUSY_DATA 5
`define STS_ALIGN_ERR 4
// Reset values
`define RST_CMD_CONFIG 8'h00
`define RST_ERR_CONFIG 8'h00
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// Array geometry
`define PHRASE_MASK 18'h00007
`define HALF_MASK 18'h00003
`define PROG_SECTOR_MASK 18'h001FF
`define DATA_SECTOR_MASK 18'h00003
// Information region in the program array
`define INFO_BASE 18'h04000
`define INFO_LAST 18'h040FF
`define VERSION_ID_ADDR 18'h040B6
`define ONCE_FIELD_BASE 18'h040C0
`define ONCE_FIELD_BYTES 8'h40
`endif

// [flash_pkg.sv]
// Types shared by the flash read, ECC and interrupt controller
package flash_pkg;
  // AXI4-Lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;
  // AXI4-Lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;
  // Array read request from the core
  typedef struct packed {
    logic valid;
    logic data_array;
    logic word;
    logic [17:0] addr;
  } rd_req_t;
  // Array read answer
  typedef struct packed {
    logic ready;
    logic ack;
    logic err;
    logic [15:0] data;
  } rd_rsp_t;
  // Sequencer operations
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10
  } seq_op_t;
  // Requests and status from the command sequencer
  typedef struct packed {
    seq_op_t op;
    logic data_array;
    logic [17:0] addr;
    logic [63:0] phrase;
    logic busy_prog;
    logic busy_data;
    logic complete;
  } seq_req_t;
  // Write or erase order towards the array
  typedef struct packed {
    seq_op_t op;
    logic data_array;
    logic [17:0] addr;
    logic [63:0] phrase;
    logic [13:0] check;
  } arr_wr_t;
  // Complete controller state
  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] cmd_config;
    logic [7:0] err_config;
    logic done_flag;
    logic align_err;
    logic dbl_flag;
    logic sgl_flag;
    logic cmd_start;
    logic rd_ack;
    logic rd_err;
    logic [15:0] rd_data;
    arr_wr_t wr;
  } ctrl_state_t;
endpackage

// [tb_top.sv]
// Self-checking bench for the flash read, ECC and interrupt controller
`timescale 1ns/1ps
`include "flash_defines.svh"
module tb_top;
  import flash_pkg::*;
  localparam logic [7:0] A_CFG = {1'b0, `IDX_CMD_CONFIG, 2'b00};
  localparam logic [7:0] A_ERC = {1'b0, `IDX_ERR_CONFIG, 2'b00};
  localparam logic [7:0] A_STS = {1'b0, `IDX_CMD_STATUS, 2'b00};
  localparam logic [7:0] A_ERS = {1'b0, `IDX_ERR_STATUS, 2'b00};
  logic sys_clk, reset_n, arr_data_sel, arr_info_sel, cmd_start;
  logic irq_cmd, irq_err, re; // Interrupts and read error
  axil_req_t axi_req;
  axil_rsp_t axi_rsp;
  rd_req_t rd_req;
  rd_rsp_t rd_rsp;
  seq_req_t seq_req;
  arr_wr_t arr_wr;
  logic [17:0] arr_addr, ad; // Array address and stimulus address
  logic [38:0] arr_rdata;
  logic [1:0] flip, rs; // Fault injection and bus response
  logic [15:0] rd;
  logic [31:0] rv;
  logic [63:0] ph;
  int n_fail, checks_done, seed, n_start;
  // Counts command launches seen on cmd_start
  always @(posedge sys_clk) begin
    if (cmd_start) n_start <= n_start + 1;
  end
  // Design and far-side array
  flash_ctrl dut_u (.sys_clk, .reset_n, .axi_req, .axi_rsp, .rd_req,
    .rd_rsp, .arr_addr, .arr_data_sel, .arr_info_sel, .arr_rdata,
    .seq_req, .cmd_start, .arr_wr, .irq_cmd, .irq_err);
  flash_array_model arr_u (.sys_clk, .reset_n, .arr_addr, .arr_data_sel,
    .arr_rdata, .arr_wr, .flip);
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
               got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Checks %0d, failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Bus write: both channels offered, each released once taken
  task automatic wrc(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge sys_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= {24'h000000, d};
    axi_req.wstrb <= 4'hF;
    axi_req.bready <= 1'b1;
    while (pa || pw) begin
      @(negedge sys_clk);
      ta = pa && axi_rsp.awready;
      tw = pw && axi_rsp.wready;
      @(posedge sys_clk);
      if (ta) axi_req.awvalid <= 1'b0;
      if (tw) axi_req.wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    @(negedge sys_clk);
    while (!axi_rsp.bvalid) begin
      @(negedge sys_clk);
    end
    chk(32'(axi_rsp.bresp), 32'(er), "write response");
    @(posedge sys_clk);
    axi_req.bready <= 1'b0;
  endtask
  // Bus read with expected data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    @(negedge sys_clk);
    while (!axi_rsp.arready) begin
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b0;
    @(negedge sys_clk);
    while (!axi_rsp.rvalid) begin
      @(negedge sys_clk);
    end
    chk(32'(axi_rsp.rresp), 32'(er), "read response");
    if (er == `RESP_OKAY) chk(axi_rsp.rdata, ed, "read data");
    @(posedge sys_clk);
    axi_req.rready <= 1'b0;
  endtask
  // Array read; the answer is due one cycle after the request is taken
  task automatic arr_rd(input logic da, input logic w, input logic [17:0] a);
    @(posedge sys_clk);
    rd_req <= '{valid: 1'b1, data_array: da, word: w, addr: a};
    @(negedge sys_clk);
    while (!rd_rsp.ready) begin
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    rd_req.valid <= 1'b0;
    @(negedge sys_clk);
    chk(32'(rd_rsp.ack), 32'h1, "read ack");
    rd = rd_rsp.data;
    re = rd_rsp.err;
  endtask
  // Sequencer order, then settle on the cycle arr_wr answers
  task automatic seq_cmd(input seq_op_t op, input logic da,
                         input logic [17:0] a);
    @(posedge sys_clk);
    seq_req.op <= op;
    seq_req.data_array <= da;
    seq_req.addr <= a;
    seq_req.phrase <= ph;
    @(posedge sys_clk);
    seq_req.op <= OP_NONE;
    @(negedge sys_clk);
  endtask
  task automatic chk_irq(input logic c, input logic e);
    @(negedge sys_clk);
    chk(32'({irq_cmd, irq_err}), 32'({c, e}), "interrupt lines");
  endtask
  // Expected array data from a phrase, address and width
  function automatic logic [15:0] exp_rd(input logic [63:0] p,
                                         input logic [17:0] a, input logic w);
    logic [31:0] h;
    logic [15:0] wd;
    h = a[2] ? p[63:32] : p[31:0];
    wd = a[1] ? h[31:16] : h[15:0];
    if (w) return wd;
    return {8'h00, a[0] ? wd[15:8] : wd[7:0]};
  endfunction
  initial begin
    seed = 32'hC793;
    {n_fail, checks_done, n_start} = '0;
    {reset_n, flip, axi_req, rd_req, seq_req} = '0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Reset values, reserved and unmapped places
    rdc(A_CFG, 32'(`RST_CMD_CONFIG), `RESP_OKAY);
    rdc(8'h4C, 32'h0, `RESP_OKAY);
    rdc(8'h50, 32'h0, `RESP_SLVERR);
    wrc(8'h50, 8'hFF, `RESP_SLVERR);
    repeat (4) begin
      rv = $random(seed);
      wrc(A_CFG, rv[7:0], `RESP_OKAY);
      rdc(A_CFG, 32'(rv[7:0] & 8'h93), `RESP_OKAY);
    end
    wrc(A_CFG, 8'h00, `RESP_OKAY);
    wrc(A_ERC, 8'h03, `RESP_OKAY);
    // Erased bytes and aligned words at random places
    repeat (6) begin
      rv = $random(seed);
      ad = {12'h000, rv[5:1], rv[6] ? 1'b0 : rv[0]};
      arr_rd(1'b0, rv[6], ad);
      chk(32'(rd), 32'(exp_rd('1, ad, rv[6])), "erased data");
      chk(32'(re), 32'h0, "erased error");
    end
    rdc(A_ERS, 32'h0, `RESP_OKAY);
    arr_rd(1'b0, 1'b1, 18'h00001);
    chk(32'(re), 32'h1, "misaligned word");
    wrc(A_ERS, 8'h03, `RESP_OKAY);
    // Forced single fault, then forced double fault
    wrc(A_CFG, 8'h01, `RESP_OKAY);
    arr_rd(1'b0, 1'b0, 18'h00004);
    rdc(A_ERS, 32'h1, `RESP_OKAY);
    chk_irq(1'b0, 1'b1);
    rdc(A_CFG, 32'h1, `RESP_OKAY);
    wrc(A_CFG, 8'h02, `RESP_OKAY);
    wrc(A_ERS, 8'h01, `RESP_OKAY);
    chk_irq(1'b0, 1'b0);
    arr_rd(1'b0, 1'b1, 18'h00006);
    chk(32'(re), 32'h1, "forced double");
    rdc(A_ERS, 32'h2, `RESP_OKAY);
    chk_irq(1'b0, 1'b1);
    wrc(A_ERC, 8'h01, `RESP_OKAY);
    chk_irq(1'b0, 1'b0);
    rdc(A_CFG, 32'h2, `RESP_OKAY);
    wrc(A_CFG, 8'h00, `RESP_OKAY);
    wrc(A_ERS, 8'h03, `RESP_OKAY);
    wrc(A_ERC, 8'h03, `RESP_OKAY);
    // Genuine faults on a programmed phrase: suppressed single, single, double
    ph = {$random(seed), $random(seed)};
    seq_cmd(OP_PROG, 1'b0, 18'h00010);
    for (int k = 0; k < 3; k++) begin
      wrc(A_CFG, (k == 0) ? 8'h10 : 8'h00, `RESP_OKAY);
      flip <= (k == 2) ? 2'h2 : 2'h1;
      arr_rd(1'b0, 1'b1, 18'h00010);
      flip <= 2'h0;
      if (k < 2) chk(32'(rd), 32'(exp_rd(ph, 18'h00010, 1'b1)),
                     "corrected word");
      chk(32'(re), 32'(k == 2), "fault error");
      rdc(A_ERS, (k == 0) ? 32'h0 : 32'(k), `RESP_OKAY);
      wrc(A_ERS, 8'h03, `RESP_OKAY);
    end
    // Erase to sector bases, program a phrase, read it back
    seq_cmd(OP_ERASE, 1'b0, 18'h00345);
    chk(32'(arr_wr.addr), 32'h200, "program sector");
    seq_cmd(OP_ERASE, 1'b1, 18'h00347);
    chk(32'(arr_wr.addr), 32'h344, "data sector");
    ph = {$random(seed), $random(seed)};
    seq_cmd(OP_PROG, 1'b0, 18'h00028);
    chk(32'(arr_wr.op), 32'(OP_PROG), "program order");
    for (int j = 0; j < 4; j++) begin
      ad = 18'h00028 + 18'(2 * j);
      flip <= (j == 3) ? 2'h1 : 2'h0;
      arr_rd(1'b0, 1'b1, ad);
      chk(32'(rd), 32'(exp_rd(ph, ad, 1'b1)), "phrase word");
    end
    flip <= 2'h0;
    rdc(A_ERS, 32'h1, `RESP_OKAY);
    wrc(A_ERS, 8'h03, `RESP_OKAY);
    seq_cmd(OP_PROG, 1'b0, 18'h00024);
    chk(32'(arr_wr.op), 32'(OP_NONE), "misaligned phrase");
    rdc(A_STS, 32'h10, `RESP_OKAY);
    wrc(A_STS, 8'h10, `RESP_OKAY);
    // Command complete interrupt follows flag and enable
    @(posedge sys_clk);
    seq_req.complete <= 1'b1;
    @(posedge sys_clk);
    seq_req.complete <= 1'b0;
    chk_irq(1'b0, 1'b0);
    wrc(A_CFG, 8'h80, `RESP_OKAY);
    chk_irq(1'b1, 1'b0);
    wrc(A_CFG, 8'h00, `RESP_OKAY);
    chk_irq(1'b0, 1'b0);
    rdc(A_STS, 32'h80, `RESP_OKAY);
    wrc(A_STS, 8'h80, `RESP_OKAY);
    rdc(A_STS, 32'h0, `RESP_OKAY);
    chk(32'(n_start), 32'h1, "command launch");
    // Arbitration between arrays while commands run
    @(posedge sys_clk);
    seq_req.busy_prog <= 1'b1;
    rd_req.data_array <= 1'b1;
    @(negedge sys_clk);
    chk(32'(rd_rsp.ready), 32'h0, "data read held");
    wrc(A_CFG, 8'h80, `RESP_SLVERR);
    rdc(A_STS, 32'h40, `RESP_OKAY);
    // A data read waits until the program command ends
    fork
      arr_rd(1'b1, 1'b0, 18'h00345);
      begin
        repeat (3) @(posedge sys_clk);
        seq_req.busy_prog <= 1'b0;
      end
    join
    chk(32'(rd), 32'(exp_rd('1, 18'h00345, 1'b0)), "data read");
    @(posedge sys_clk);
    seq_req.busy_data <= 1'b1;
    arr_rd(1'b0, 1'b1, 18'h040B6);
    chk(32'(rd), 32'hFFFF, "program read");
    chk(32'(arr_info_sel), 32'h1, "info region");
    @(posedge sys_clk);
    seq_req.busy_data <= 1'b0;
    repeat (2) @(posedge sys_clk);
    print_verdict();
  end
endmodule
